/* File: core/sram_ctrl_pkg.sv */
// Package: memory geometry, pin timing and controller states for the static memory controller
package sram_ctrl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CLK_PERIOD_NS = 50;
    // Worst-case speed grade figures, in ns
    localparam int ACCESS_NS = 25;
    localparam int WRITE_PULSE_NS = 12;
    localparam int CS_TO_END_NS = 15;
    localparam int ADDR_TO_END_NS = 14;
    localparam int LANE_TO_END_NS = 14;
    localparam int DATA_SETUP_NS = 10;
    localparam int FLOAT_NS = 8;
    localparam int HOLD_NS = 5;
    // Least times round up, at least one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int READ_CYC = cyc_up(ACCESS_NS);
    localparam int WRITE_CYC_A = cyc_up(WRITE_PULSE_NS) > cyc_up(CS_TO_END_NS) ?
                                 cyc_up(WRITE_PULSE_NS) : cyc_up(CS_TO_END_NS);
    localparam int WRITE_CYC_B = cyc_up(ADDR_TO_END_NS) > cyc_up(LANE_TO_END_NS) ?
                                 cyc_up(ADDR_TO_END_NS) : cyc_up(LANE_TO_END_NS);
    localparam int WRITE_CYC_C = WRITE_CYC_A > WRITE_CYC_B ? WRITE_CYC_A : WRITE_CYC_B;
    localparam int WRITE_CYC = WRITE_CYC_C > cyc_up(DATA_SETUP_NS) ? WRITE_CYC_C : cyc_up(DATA_SETUP_NS);
    localparam int TURN_CYC = cyc_up(FLOAT_NS);
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {IDLE, RD_WAIT, WR_SETUP, WR_PULSE, WR_END, TURN} state_t;
endpackage

/* File: core/sram_pin_if.sv */
// Interface: memory pin bundle between sequencer and pin driver
`timescale 1ns/1ps
interface sram_pin_if;
    logic chipSel;
    logic outEnable;
    logic writeEnable;
    logic [1:0] laneEnable;
    logic driveBus;
    modport seq(output chipSel, output outEnable, output writeEnable, output laneEnable, output driveBus);
    modport pins(input chipSel, input outEnable, input writeEnable, input laneEnable, input driveBus);
endinterface

/* File: core/sram_pin_drive.sv */
// Pin driver: registers the memory control strobes and the data output enables
`timescale 1ns/1ps
module sram_pin_drive
    import sram_ctrl_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    sram_pin_if.pins pin, // Requested pin levels
    output logic chip_sel_n, // Chip select to memory
    output logic out_enable_n, // Output enable to memory
    output logic write_enable_n, // Write enable to memory
    output logic low_lane_enable_n, // Lower byte lane enable
    output logic high_lane_enable_n, // Upper byte lane enable
    output logic [DATA_W-1:0] data_pins_oe_n // Data pin output enables, low drives
);
    // Registered strobes keep glitches off asynchronous memory inputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            chip_sel_n <= 1'b1;
            out_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            low_lane_enable_n <= 1'b1;
            high_lane_enable_n <= 1'b1;
            data_pins_oe_n <= '1;
        end else begin
            chip_sel_n <= ~pin.chipSel;
            out_enable_n <= ~pin.outEnable;
            write_enable_n <= ~pin.writeEnable;
            low_lane_enable_n <= ~pin.laneEnable[0];
            high_lane_enable_n <= ~pin.laneEnable[1];
            data_pins_oe_n <= {DATA_W{~pin.driveBus}};
        end
    end
endmodule

/* File: core/sram_ctrl.sv */
// Controller top: sequences reads and writes onto an asynchronous 64K x 16 static memory
`timescale 1ns/1ps
// Summary of operation
// - Write enable stays high for the whole read cycle.
// - Chip select held low at least the select-to-end time before write end.
// - Address valid the address-to-end time before write end, held after.
// - Byte lanes enabled the lane-to-end time before write end.
module sram_ctrl
    import sram_ctrl_pkg::*;
(
    input wire logic clk, // System clock, 20 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic reqValid, // Request present
    output logic reqReady, // Request taken this cycle
    input wire logic reqWrite, // 1 write, 0 read
    input wire logic [ADDR_W-1:0] reqAddr, // Word address
    input wire logic [DATA_W-1:0] reqData, // Write data
    input wire logic [1:0] reqLanes, // Lane select, bit0 low byte, bit1 high byte
    output logic rspValid, // Read data valid pulse
    output logic [DATA_W-1:0] rspData, // Read data
    output logic [ADDR_W-1:0] word_address, // Address to memory
    input wire logic [DATA_W-1:0] data_pins_i, // Data pins level from memory
    output logic [DATA_W-1:0] data_pins_o, // Data pins driven value
    output logic [DATA_W-1:0] data_pins_oe_n, // Data pins output enable, low drives
    output logic chip_sel_n, // Chip select
    output logic out_enable_n, // Output enable
    output logic write_enable_n, // Write enable
    output logic low_lane_enable_n, // Lower byte lane enable
    output logic high_lane_enable_n // Upper byte lane enable
);
    import sram_ctrl_pkg::*;

    sram_pin_if pinReq();
    state_t state, next_state;
    logic [CNT_W-1:0] count;
    logic [1:0] lanes;
    logic [CNT_W-1:0] next_count;

    wire idle = (state == IDLE);
    wire cntDone = (count == '0);
    wire take = idle && reqValid;
    assign reqReady = take;

    always_comb begin
        next_state = state;
        next_count = (count == '0) ? count : count - 1'b1;
        unique case (state)
            IDLE: begin
                if (reqValid && reqWrite) begin
                    next_state = WR_SETUP;
                    next_count = '0;
                end else if (reqValid) begin
                    next_state = RD_WAIT;
                    next_count = CNT_W'(READ_CYC);
                end
            end
            RD_WAIT: begin
                if (cntDone) begin
                    next_state = TURN;
                    next_count = CNT_W'(TURN_CYC - 1);
                end
            end
            WR_SETUP: begin
                next_state = WR_PULSE;
                next_count = CNT_W'(WRITE_CYC - 1);
            end
            WR_PULSE: begin
                if (cntDone) begin
                    next_state = WR_END;
                end
            end
            WR_END: next_state = IDLE;
            TURN: begin
                if (cntDone) begin
                    next_state = IDLE;
                end
            end
        endcase
    end

    // Requested pin levels, decoded from next_state and registered by the pin driver
    assign pinReq.chipSel = (next_state != IDLE) && (next_state != TURN);
    assign pinReq.writeEnable = (next_state == WR_PULSE);
    assign pinReq.outEnable = (next_state == RD_WAIT);
    assign pinReq.laneEnable = (next_state == IDLE || next_state == TURN) ? 2'b00 :
                               (take ? reqLanes : lanes);
    // Bus driven only on the write path; released before any read enables outputs
    assign pinReq.driveBus = (next_state == WR_SETUP) || (next_state == WR_PULSE) ||
                             (next_state == WR_END);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= IDLE;
            count <= '0;
            lanes <= 2'b00;
            word_address <= '0;
            data_pins_o <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            if (take) begin
                lanes <= reqLanes;
                word_address <= reqAddr;
                data_pins_o <= reqData;
            end
        end
    end

    // Sample in the last read cycle; unselected lanes read as zero
    wire sampleNow = (state == RD_WAIT) && cntDone;
    wire [DATA_W-1:0] laneMask = {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rspValid <= 1'b0;
            rspData <= '0;
        end else begin
            rspValid <= sampleNow;
            if (sampleNow) begin
                rspData <= data_pins_i & laneMask;
            end
        end
    end

    sram_pin_drive drive (
        .clk(clk),
        .nrst(nrst),
        .pin(pinReq),
        .chip_sel_n(chip_sel_n),
        .out_enable_n(out_enable_n),
        .write_enable_n(write_enable_n),
        .low_lane_enable_n(low_lane_enable_n),
        .high_lane_enable_n(high_lane_enable_n),
        .data_pins_oe_n(data_pins_oe_n)
    );
endmodule

/* File: tb/sram_model.sv */
// Partner model: behavioural 64K x 16 static memory
`timescale 1ns/1ps
module sram_model (
    input wire logic [15:0] addr, // Word address
    input wire logic [15:0] bus, // Resolved data pins
    input wire logic csN, oeN, weN, loN, hiN, // Active-low strobes
    output logic [15:0] q, // Offered data
    output logic [15:0] en // High where memory drives
);
    logic [15:0] mem [0:65535];
    logic [15:0] last = 16'h0000;
    wire rd = !csN && !oeN && weN;
    assign en = {{8{rd && !hiN}}, {8{rd && !loN}}};
    // Floating lanes show the inverse of the last value, so a stale sample never matches
    assign q = (en & mem[addr]) | (~en & ~last);
    initial foreach (mem[i]) mem[i] = 16'h0000;
    always @* if (rd) last = mem[addr];
    always @(posedge weN) if (!csN) begin
        if (!loN) mem[addr][7:0] = bus[7:0];
        if (!hiN) mem[addr][15:8] = bus[15:8];
    end
endmodule

/* File: tb/sram_ctrl_checker.sv */
// Checker: pin sequencing of the static memory controller
`timescale 1ns/1ps
module sram_ctrl_checker
    import sram_ctrl_pkg::*;
(
    input wire logic clk, nrst, reqValid, reqReady, reqWrite, rspValid, // Handshake
    input wire logic [ADDR_W-1:0] word_address, // Address
    input wire logic [DATA_W-1:0] data_pins_oe_n, // Bus drive, low drives
    input wire logic chip_sel_n, out_enable_n, write_enable_n, low_lane_enable_n, high_lane_enable_n // Strobes
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence csRelease;
        !chip_sel_n ##1 chip_sel_n;
    endsequence
    a_read_we_high: assert property (!out_enable_n |-> write_enable_n) else $error("we low in read");
    a_cs_leads_we: assert property ($fell(write_enable_n) |-> $past(!chip_sel_n)) else $error("cs late");
    a_we_ends_first: assert property ($rose(write_enable_n) |-> csRelease) else $error("cs early");
    a_addr_held: assert property ($fell(write_enable_n) |-> $stable(word_address) ##1 $stable(word_address))
        else $error("addr moved");
    a_lanes_set: assert property (!write_enable_n |-> $stable({low_lane_enable_n, high_lane_enable_n}))
        else $error("lanes moved");
    a_bus_free: assert property (!out_enable_n |-> &data_pins_oe_n) else $error("bus clash");
    a_oe_off_write: assert property (!write_enable_n |-> out_enable_n) else $error("oe in write");
    a_read_answer: assert property (reqValid && reqReady && !reqWrite |-> ##[3:4] rspValid)
        else $error("no read data");
endmodule
bind sram_ctrl sram_ctrl_checker chk (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .rspValid(rspValid), .word_address(word_address), .data_pins_oe_n(data_pins_oe_n),
    .chip_sel_n(chip_sel_n), .out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n));

/* File: tb/testbench.sv */
// Testbench: random reads and writes through the controller into the memory model
`timescale 1ns/1ps
module testbench;
    import sram_ctrl_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
    logic [15:0] reqAddr = 16'h0000, reqData = 16'h0000;
    logic [1:0] reqLanes = 2'h0;
    logic reqReady, rspValid, csN, oeN, weN, loN, hiN;
    logic [15:0] rspData, addr, dOut, dOeN, q, en, pins;
    logic [15:0] refMem [int];
    logic [15:0] expQ [$];
    logic [31:0] seed = 32'h0000_04af;
    int num_errors = 0;
    int comparisons = 0;
    bit hung = 1'b0;
    // Controller wins any clash; the checker flags a clash separately
    assign pins = (~dOeN & dOut) | (dOeN & q);
    sram_ctrl dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .reqLanes(reqLanes), .rspValid(rspValid), .rspData(rspData),
        .word_address(addr), .data_pins_i(pins), .data_pins_o(dOut), .data_pins_oe_n(dOeN), .chip_sel_n(csN),
        .out_enable_n(oeN), .write_enable_n(weN), .low_lane_enable_n(loN), .high_lane_enable_n(hiN));
    sram_model mem (.addr(addr), .bus(pins), .csN(csN), .oeN(oeN), .weN(weN), .loN(loN), .hiN(hiN),
        .q(q), .en(en));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] mask(input logic [1:0] l);
        return {{8{l[1]}}, {8{l[0]}}};
    endfunction
    task automatic give_verdict;
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic send(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] l);
        int i;
        logic [15:0] old;
        // Once a request has hung, the rest of the run falls through to the verdict
        if (hung) return;
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqData <= d;
        reqLanes <= l;
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            if (reqReady === 1'b1) break;
        end
        if (i == 20) begin
            num_errors++;
            hung = 1'b1;
            reqValid <= 1'b0;
            return;
        end
        @(posedge clk);
        old = refMem.exists(a) ? refMem[a] : 16'h0000;
        if (w) refMem[a] = (old & ~mask(l)) | (d & mask(l));
        else expQ.push_back(old & mask(l));
    endtask
    always @(negedge clk) if (rspValid === 1'b1) begin
        if (expQ.size() == 0) chk("rspCount", 16'h0001, 16'h0000);
        else chk("rspData", expQ.pop_front(), rspData);
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        send(1'b1, 16'hffff, 16'ha5c3, 2'h3);
        send(1'b0, 16'hffff, 16'h0000, 2'h3);
        send(1'b1, 16'h0000, 16'h1234, 2'h1);
        send(1'b0, 16'h0000, 16'h0000, 2'h2);
        send(1'b0, 16'h0000, 16'h0000, 2'h0);
        repeat (80) begin
            seed = xs(seed);
            send(seed[0], {seed[1] ? 13'h1fff : 13'h0000, seed[4:2]}, seed[31:16], seed[6:5]);
            if (seed[7]) begin
                reqValid <= 1'b0;
                @(posedge clk);
            end
        end
        reqValid <= 1'b0;
        repeat (10) @(posedge clk);
        chk("rspLeft", 16'h0000, 16'(expQ.size()));
        give_verdict;
    end
endmodule
